// ### mpfm_defines.svh
// Timing, field and code constants of the motor power stage fault manager.
`ifndef MPFM_DEFINES_SVH
`define MPFM_DEFINES_SVH
`define MPFM_CLK_NS        8
`define MPFM_TICK_NS       100000
`define MPFM_STEP_NS       200
`define MPFM_STEP_CYC      (`MPFM_STEP_NS / `MPFM_CLK_NS)
`define MPFM_PWM_MIN_MHZ   5300
`define MPFM_NOFREQ_TICKS  (64'd1000000000000 / (`MPFM_PWM_MIN_MHZ * `MPFM_TICK_NS))
`define MPFM_WDT_UNIT_US   1600
`define MPFM_WDT_TICKS     (`MPFM_WDT_UNIT_US * 1000 / `MPFM_TICK_NS)
`define MPFM_RESTART_MS    50
`define MPFM_RESTART_TICKS (`MPFM_RESTART_MS * 1000000 / `MPFM_TICK_NS)
`define MPFM_SS_UNIT_US    6400
`define MPFM_SS_TICKS      (`MPFM_SS_UNIT_US * 1000 / `MPFM_TICK_NS)
`define MPFM_SS_STEPS      5'h10
`define MPFM_TJ_LOW        8'd150
`define MPFM_TJ_HIGH       8'd175
`define MPFM_TJ_MARGIN     8'd25
`define MPFM_DUTY_FULL     10'h3ff
`define MPFM_SLEW_UNIT     10'h01a
`define MPFM_SLEW_MAXSEL   3'h6
`define MPFM_CMD_KICK      8'h00
`define MPFM_CMD_CLEAR     8'hff
`define MPFM_DIAG0_ADDR    16'h0201
`define MPFM_D0_OC         0
`define MPFM_D0_VSLV       1
`define MPFM_D0_VSOV       2
`define MPFM_D0_CPLV       3
`define MPFM_D0_VGLLV      4
`define MPFM_D0_SHORT      5
`define MPFM_D0_EXTOT      6
`define MPFM_D0_LOCK       7
`define MPFM_FB_STOP       3'h0
`define MPFM_FB_TAG_LOW    3'h5
`define MPFM_FB_TAG_HIGH   3'h6
`endif

// ### mpfm_pkg.sv
// Types shared by the motor power stage fault manager.
package mpfm_pkg;
   typedef struct packed {
      logic       fault_polarity_bit;
      logic       latched_only_fault_output;
      logic [2:0] fallback_zero_select;
      logic [2:0] fallback_full_select;
      logic       duty_slew_en;
      logic [2:0] duty_slew_select;
      logic [1:0] pulse_ratio_config;
      logic [4:0] dead_time_field;
      logic [3:0] short_threshold_field;
      logic [3:0] short_mask_time;
      logic       limit_threshold_select;
      logic [3:0] limit_blanking_time;
      logic [5:0] soft_start_time;
      logic       overcurrent_protect_enable;
      logic [1:0] overcurrent_offset_select;
      logic [3:0] overcurrent_blanking_time;
      logic       junction_shutoff_select;
      logic [1:0] external_temp_threshold;
      logic       watchdog_enable_bit;
      logic [5:0] watchdog_timeout;
      logic [2:0] watchdog_action_select;
      logic       overvoltage_protect_enable;
      logic       short_protect_enable;
      logic       overcurrent_latch_bit;
      logic       short_latch_bit;
      logic       lock_latch_bit;
   } mpfm_cfg_t;

   typedef struct packed {
      logic [4:0] limit_level;
      logic       limit_threshold_select;
      logic [1:0] overcurrent_offset_select;
      logic [3:0] short_threshold_field;
      logic [1:0] external_temp_threshold;
      logic       junction_shutoff_select;
   } mpfm_ref_t;

   typedef enum logic [1:0] {
      PR_RUN   = 2'b00,
      PR_WAIT  = 2'b01,
      PR_LATCH = 2'b11
   } mpfm_prot_t;
endpackage

// ### mpfm_top.sv
// Protection, fault handling and gate sequencing of a three-phase power stage.
// Notes on behaviour
// RL1 - No PWM edges: flag fault, pick level mode.
// RL2 - Fallback duty: stop, quarters or target levels.
// RL3 - Optional clamp on each request or fallback duty change.
// RL4 - Feedback pin toggles per back-EMF transitions ratio.
// RL5 - Errors and warnings drive fault pin, selectable polarity.
// RL6 - Faults self-recover unless latching enabled.
// RL7 - Dead time before complementary gate turns on.
// RL8 - Drain-source short detect with mask time.
// RL9 - Current limit turns bridge off until period.
// RL10 - Current limit ignored during blanking time.
// RL11 - Soft-start ramps limit in sixteen steps.
// RL12 - Over-current beyond offset forces gates low.
// RL13 - Unlatched over-current or short restarts after 50ms.
// RL14 - Thermal warning 25 degrees below selected shutoff.
// RL15 - External over-temperature disables gates, sets flag.
// RL16 - Watchdog expires unless kicked by 00h write.
// RL17 - Watchdog timeout applies selected duty directly.
// RL18 - Latched faults hold until a clearing action.
// RL19 - Latched-only mode: only latched errors drive pin.
// RL20 - Supply faults stop motor, recover automatically.
// RL21 - Sleep leaves all gate outputs high impedance.
// RL22 - Diagnostic flags follow active or latched faults.
`timescale 1ns/1ns
`include "mpfm_defines.svh"
module mpfm_top
   import mpfm_pkg::*;
#(
   parameter int unsigned TICK_CYC = `MPFM_TICK_NS / `MPFM_CLK_NS
) (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       pwm_in,
   input  wire logic       en_pin,
   input  wire logic       bemf_cmp,
   input  wire logic       limit_cmp,
   input  wire logic       overcurrent_cmp,
   input  wire logic       short_cmp,
   input  wire logic       ext_temp_cmp,
   input  wire logic       vs_low_cmp,
   input  wire logic       vs_high_cmp,
   input  wire logic       pump_low_cmp,
   input  wire logic       vgl_low_cmp,
   input  wire logic       sleep_mode,
   input  wire logic       lock_detect,
   input  wire logic [9:0] duty_request,
   input  wire logic [9:0] target_low,
   input  wire logic [9:0] target_high,
   input  wire logic       zero_command,
   input  wire logic       pwm_period_start,
   input  wire logic [2:0] high_req,
   input  wire logic [2:0] low_req,
   input  wire logic [7:0] die_temp,
   input  wire mpfm_cfg_t  cfg,
   input  wire logic       reset_cmd_wr,
   input  wire logic [7:0] reset_cmd_data,
   output logic [2:0]      gate_high_q,
   output logic [2:0]      gate_low_q,
   output logic            gate_oe_q,
   output logic [9:0]      duty_out_q,
   output mpfm_ref_t       analog_ref_q,
   output logic            speed_feedback_pin_q,
   output logic            speed_feedback_pin_oe_q,
   output logic            fault_output_pin_q,
   output logic            fault_output_pin_oe_q,
   output logic [7:0]      diagnostic_errors_zero_q,
   output logic            pwm_input_fault_flag_q,
   output logic            thermal_warning_q,
   output logic            watchdog_fault_q,
   output logic            current_limit_warning_q
);
   localparam int unsigned NSYNC = 11;

   logic [NSYNC-1:0] async_w;
   logic [NSYNC-1:0] meta_q;
   logic [NSYNC-1:0] sync_q;
   logic             pwm_s, en_s, bemf_s, lim_s, oc_s, sh_s, ext_s;
   logic             vslv_s, vsov_s, cplv_s, vgllv_s;

   assign async_w = {vgl_low_cmp, pump_low_cmp, vs_high_cmp, vs_low_cmp, ext_temp_cmp,
                     short_cmp, overcurrent_cmp, limit_cmp, bemf_cmp, en_pin, pwm_in};
   assign {vgllv_s, cplv_s, vsov_s, vslv_s, ext_s, sh_s, oc_s, lim_s, bemf_s, en_s, pwm_s}
      = sync_q;

   // Two-stage synchronisers for every pin and comparator.
   for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            meta_q[i] <= 1'b0;
            sync_q[i] <= 1'b0;
         end else begin
            meta_q[i] <= async_w[i];
            sync_q[i] <= meta_q[i];
         end
      end
   end

   // Slow time base of one pulse per tick.
   logic [31:0] tick_cnt_q;
   logic        tick_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_q <= 32'h0;
         tick_q     <= 1'b0;
      end else begin
         tick_q     <= (tick_cnt_q == TICK_CYC - 1);
         tick_cnt_q <= (tick_cnt_q == TICK_CYC - 1) ? 32'h0 : tick_cnt_q + 32'h1;
      end
   end

   // Clearing actions for latched faults.
   logic clear_evt, kick_evt;
   assign clear_evt = !en_s || zero_command ||
                      (reset_cmd_wr && reset_cmd_data == `MPFM_CMD_CLEAR); // [RL18]
   assign kick_evt  = reset_cmd_wr && reset_cmd_data == `MPFM_CMD_KICK; // [RL16]

   // Missing PWM frequency detection.
   logic        pwm_d_q, pwm_edge;
   logic [15:0] nofreq_cnt_q;
   assign pwm_edge = pwm_s ^ pwm_d_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwm_d_q                <= 1'b0;
         nofreq_cnt_q           <= 16'h0;
         pwm_input_fault_flag_q <= 1'b0;
      end else begin
         pwm_d_q <= pwm_s;
         if (pwm_edge) begin
            nofreq_cnt_q           <= 16'h0;
            pwm_input_fault_flag_q <= 1'b0;
         end else begin
            if (tick_q && nofreq_cnt_q < 16'(`MPFM_NOFREQ_TICKS))
               nofreq_cnt_q <= nofreq_cnt_q + 16'h1;
            pwm_input_fault_flag_q <= (nofreq_cnt_q >= 16'(`MPFM_NOFREQ_TICKS)); // [RL1]
         end
      end
   end

   // Watchdog counted in ticks, restarted by the kick command.
   logic [11:0] wdt_cnt_q;
   logic [11:0] wdt_lim;
   assign wdt_lim = 12'((cfg.watchdog_timeout + 7'h1) * `MPFM_WDT_TICKS);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdt_cnt_q        <= 12'h0;
         watchdog_fault_q <= 1'b0;
      end else if (!cfg.watchdog_enable_bit || kick_evt) begin
         wdt_cnt_q        <= 12'h0;
         watchdog_fault_q <= 1'b0;
      end else if (tick_q && !watchdog_fault_q) begin
         wdt_cnt_q <= wdt_cnt_q + 12'h1;
         if (wdt_cnt_q + 12'h1 >= wdt_lim)
            watchdog_fault_q <= 1'b1; // [RL16]
      end
   end

   // Fixed duty of a fallback selection.
   function automatic logic [9:0] fb_duty(input logic [2:0] sel);
      logic [11:0] q;
      q = 12'h0;
      if (sel == `MPFM_FB_TAG_LOW)
         fb_duty = target_low;
      else if (sel == `MPFM_FB_TAG_HIGH)
         fb_duty = target_high;
      else if (sel == `MPFM_FB_STOP || sel > 3'h4)
         fb_duty = 10'h0;
      else begin
         q       = (12'(sel) * 12'(`MPFM_DUTY_FULL)) >> 2;
         fb_duty = q[9:0];
      end
   endfunction

   // Temperature and motor stop conditions.
   logic [7:0] tj_lim;
   logic       tj_shut_q;
   assign tj_lim = cfg.junction_shutoff_select ? `MPFM_TJ_HIGH : `MPFM_TJ_LOW;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tj_shut_q         <= 1'b0;
         thermal_warning_q <= 1'b0;
      end else begin
         tj_shut_q         <= die_temp >= tj_lim;
         thermal_warning_q <= die_temp >= tj_lim - `MPFM_TJ_MARGIN; // [RL14]
      end
   end

   mpfm_prot_t  prot_q;
   logic        oc_flag_q, sh_flag_q, lock_lat_q, cl_block_q;
   logic [9:0]  blank_cnt_q;
   logic        oc_evt, sh_evt, stop, allowed;
   logic [9:0]  cl_win, oc_win, sh_win;
   assign cl_win  = 10'((cfg.limit_blanking_time + 5'h1) * `MPFM_STEP_CYC);
   assign oc_win  = 10'((cfg.overcurrent_blanking_time + 5'h1) * `MPFM_STEP_CYC);
   assign sh_win  = 10'((cfg.short_mask_time + 5'h1) * `MPFM_STEP_CYC);
   assign oc_evt  = cfg.overcurrent_protect_enable && oc_s && blank_cnt_q >= oc_win; // [RL12]
   assign sh_evt  = cfg.short_protect_enable && sh_s && blank_cnt_q >= sh_win; // [RL8]
   assign stop    = prot_q != PR_RUN || vslv_s || cplv_s || vgllv_s ||
                    (cfg.overvoltage_protect_enable && vsov_s) || // [RL20]
                    ext_s || tj_shut_q || lock_detect || lock_lat_q; // [RL15]
   assign allowed = !stop && !cl_block_q; // [RL9]

   // Over-current and short shutdown with timed restart or latch.
   logic [9:0] rst_cnt_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prot_q    <= PR_RUN;
         rst_cnt_q <= 10'h0;
      end else begin
         case (prot_q)
            PR_RUN: begin
               rst_cnt_q <= 10'h0;
               if ((oc_evt && cfg.overcurrent_latch_bit) || (sh_evt && cfg.short_latch_bit))
                  prot_q <= PR_LATCH; // [RL18]
               else if (oc_evt || sh_evt)
                  prot_q <= PR_WAIT;
            end
            PR_WAIT: begin
               if ((oc_evt && cfg.overcurrent_latch_bit) || (sh_evt && cfg.short_latch_bit))
                  prot_q <= PR_LATCH;
               else if (tick_q) begin
                  rst_cnt_q <= rst_cnt_q + 10'h1;
                  if (rst_cnt_q + 10'h1 >= 10'(`MPFM_RESTART_TICKS))
                     prot_q <= PR_RUN; // [RL13] [RL6]
               end
            end
            PR_LATCH: begin
               if (clear_evt)
                  prot_q <= PR_RUN; // [RL18]
            end
            default: prot_q <= PR_RUN;
         endcase
      end
   end

   // Fault flags: a new event wins over the clear.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         oc_flag_q  <= 1'b0;
         sh_flag_q  <= 1'b0;
         lock_lat_q <= 1'b0;
      end else begin
         oc_flag_q  <= oc_evt || (oc_flag_q && prot_q != PR_RUN); // [RL22]
         sh_flag_q  <= sh_evt || (sh_flag_q && prot_q != PR_RUN); // [RL22]
         lock_lat_q <= (lock_detect && cfg.lock_latch_bit) || (lock_lat_q && !clear_evt);
      end
   end

   // Cycle-by-cycle limit, held until the next PWM period.
   logic any_on;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cl_block_q              <= 1'b0;
         current_limit_warning_q <= 1'b0;
         blank_cnt_q             <= 10'h0;
      end else begin
         if (any_on)
            blank_cnt_q <= 10'h0;
         else if (blank_cnt_q != 10'h3ff)
            blank_cnt_q <= blank_cnt_q + 10'h1;
         if (lim_s && blank_cnt_q >= cl_win) // [RL10]
            cl_block_q <= 1'b1; // [RL9]
         else if (pwm_period_start)
            cl_block_q <= 1'b0;
         current_limit_warning_q <= cl_block_q;
      end
   end

   // Soft-start ramp of the limit reference.
   logic [12:0] ss_cnt_q;
   logic [12:0] ss_lim;
   logic [4:0]  ss_level_q;
   assign ss_lim = 13'((cfg.soft_start_time + 7'h1) * `MPFM_SS_TICKS);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ss_cnt_q   <= 13'h0;
         ss_level_q <= 5'h0;
      end else if (stop || duty_out_q == 10'h0) begin
         ss_cnt_q   <= 13'h0;
         ss_level_q <= 5'h0;
      end else if (tick_q && ss_level_q < `MPFM_SS_STEPS) begin
         if (ss_cnt_q + 13'h1 >= ss_lim) begin
            ss_cnt_q   <= 13'h0;
            ss_level_q <= ss_level_q + 5'h1; // [RL11]
         end else
            ss_cnt_q <= ss_cnt_q + 13'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         analog_ref_q <= '0;
      else
         analog_ref_q <= '{ss_level_q, cfg.limit_threshold_select,
                           cfg.overcurrent_offset_select, cfg.short_threshold_field,
                           cfg.external_temp_threshold, cfg.junction_shutoff_select};
   end

   // Output duty: stop, then watchdog, then no-frequency fallback, then the request.
   logic [9:0] norm_duty, step, diff;
   logic [2:0] ssel;
   assign norm_duty = pwm_input_fault_flag_q ?
                      fb_duty(pwm_s ? cfg.fallback_full_select : cfg.fallback_zero_select)
                      : duty_request; // [RL1] [RL2]
   assign ssel = (cfg.duty_slew_select > `MPFM_SLEW_MAXSEL) ? `MPFM_SLEW_MAXSEL
                 : cfg.duty_slew_select;
   assign step = 10'(`MPFM_SLEW_UNIT * (4'h8 - 4'(ssel)));
   assign diff = (norm_duty > duty_out_q) ? norm_duty - duty_out_q : duty_out_q - norm_duty;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         duty_out_q <= 10'h0;
      else if (stop)
         duty_out_q <= 10'h0; // [RL20]
      else if (watchdog_fault_q)
         duty_out_q <= fb_duty(cfg.watchdog_action_select); // [RL17]
      else if (pwm_period_start) begin
         if (!cfg.duty_slew_en || diff <= step)
            duty_out_q <= norm_duty;
         else if (norm_duty > duty_out_q)
            duty_out_q <= duty_out_q + step; // [RL3]
         else
            duty_out_q <= duty_out_q - step; // [RL3]
      end
   end

   // Per-phase dead-time insertion.
   logic [2:0] on_rise;
   logic [9:0] dt_lim;
   assign dt_lim = 10'((cfg.dead_time_field + 6'h1) * `MPFM_STEP_CYC);
   assign any_on = |on_rise;
   for (genvar p = 0; p < 3; p++) begin : g_phase
      logic [1:0] req_q;
      logic [9:0] dt_cnt_q;
      logic       h_d, l_d;
      assign h_d = allowed && dt_cnt_q >= dt_lim && req_q == 2'b10;
      assign l_d = allowed && dt_cnt_q >= dt_lim && req_q == 2'b01;
      assign on_rise[p] = (h_d && !gate_high_q[p]) || (l_d && !gate_low_q[p]);
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            req_q          <= 2'b00;
            dt_cnt_q       <= 10'h0;
            gate_high_q[p] <= 1'b0;
            gate_low_q[p]  <= 1'b0;
         end else begin
            req_q <= {high_req[p], low_req[p]};
            if ({high_req[p], low_req[p]} != req_q)
               dt_cnt_q <= 10'h0; // [RL7]
            else if (dt_cnt_q < dt_lim)
               dt_cnt_q <= dt_cnt_q + 10'h1;
            gate_high_q[p] <= h_d; // [RL12] [RL15]
            gate_low_q[p]  <= l_d;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         gate_oe_q <= 1'b0;
      else
         gate_oe_q <= !sleep_mode; // [RL21]
   end

   // Speed feedback pin toggled every few back-EMF transitions.
   logic       bemf_d_q;
   logic [1:0] fg_cnt_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bemf_d_q                <= 1'b0;
         fg_cnt_q                <= 2'h0;
         speed_feedback_pin_q    <= 1'b0;
         speed_feedback_pin_oe_q <= 1'b0;
      end else begin
         bemf_d_q <= bemf_s;
         if (bemf_s != bemf_d_q) begin
            if (fg_cnt_q >= cfg.pulse_ratio_config) begin
               fg_cnt_q                <= 2'h0;
               speed_feedback_pin_oe_q <= !speed_feedback_pin_oe_q; // [RL4]
            end else
               fg_cnt_q <= fg_cnt_q + 2'h1;
         end
      end
   end

   // Diagnostic register and fault pin.
   logic [7:0] fault_output_pin_d;
   logic       latched_any, fault_active_d;
   always_comb begin
      fault_output_pin_d                 = 8'h0;
      fault_output_pin_d[`MPFM_D0_OC]    = oc_flag_q;
      fault_output_pin_d[`MPFM_D0_VSLV]  = vslv_s;
      fault_output_pin_d[`MPFM_D0_VSOV]  = cfg.overvoltage_protect_enable && vsov_s;
      fault_output_pin_d[`MPFM_D0_CPLV]  = cplv_s;
      fault_output_pin_d[`MPFM_D0_VGLLV] = vgllv_s;
      fault_output_pin_d[`MPFM_D0_SHORT] = sh_flag_q;
      fault_output_pin_d[`MPFM_D0_EXTOT] = ext_s; // [RL15]
      fault_output_pin_d[`MPFM_D0_LOCK]  = lock_detect || lock_lat_q;
   end
   assign latched_any    = prot_q == PR_LATCH || lock_lat_q;
   assign fault_active_d = cfg.latched_only_fault_output ? latched_any // [RL19]
                           : (|fault_output_pin_d || tj_shut_q || thermal_warning_q ||
                              watchdog_fault_q || pwm_input_fault_flag_q); // [RL5]
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         diagnostic_errors_zero_q <= 8'h0;
         fault_output_pin_q       <= 1'b0;
         fault_output_pin_oe_q    <= 1'b0;
      end else begin
         diagnostic_errors_zero_q <= fault_output_pin_d; // [RL22]
         fault_output_pin_oe_q    <= fault_active_d ^ cfg.fault_polarity_bit; // [RL5]
      end
   end

   a_sleep_hiz: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL21]
      sleep_mode |=> !gate_oe_q) else $error("gates driven in sleep");
   a_no_shoot: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL7]
      (gate_high_q & gate_low_q) == 3'h0) else $error("both gates on");
   a_dead_gap: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL7]
      $fell(gate_low_q[0]) |-> !gate_high_q[0] [*8]) else $error("dead time too short");
   a_prot_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL12]
      prot_q != PR_RUN |=> gate_high_q == 3'h0 && gate_low_q == 3'h0)
      else $error("gates on during shutdown");
   a_limit_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL9]
      cl_block_q |=> gate_high_q == 3'h0 && gate_low_q == 3'h0)
      else $error("gates on during current limit");
   a_latch_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL18]
      prot_q == PR_LATCH && !clear_evt |=> prot_q == PR_LATCH)
      else $error("latch released without clear");
   a_wdt_kick: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL16]
      kick_evt |=> !watchdog_fault_q [*2]) else $error("watchdog not restarted");
   a_edge_flag: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL1]
      pwm_edge |=> !pwm_input_fault_flag_q) else $error("fault flag despite edge");
   a_fault_output_pin_oc: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL22]
      oc_evt |=> ##1 diagnostic_errors_zero_q[`MPFM_D0_OC]) else $error("oc flag missing");
   a_fault_pol: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RL5]
      fault_active_d && !cfg.fault_polarity_bit && $stable(cfg) |=> fault_output_pin_oe_q)
      else $error("fault pin not pulled low");

   c_oc_latch: cover property (@(posedge ref_clk) disable iff (!rst_n)
      prot_q == PR_LATCH ##1 prot_q == PR_RUN);
   c_restart: cover property (@(posedge ref_clk) disable iff (!rst_n)
      prot_q == PR_WAIT ##1 prot_q == PR_RUN);
   c_nofreq: cover property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(pwm_input_fault_flag_q));
   c_wdt: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(watchdog_fault_q));
endmodule

// ### mpfm_mcu.sv
// Companion microcontroller model that writes the reset command register.
`timescale 1ns/1ns
module mpfm_mcu (
   input  wire logic       ref_clk,
   input  wire logic       req,
   input  wire logic [7:0] cmd,
   output logic            wr,
   output logic [7:0]      data
);
   initial begin
      wr = 1'b0;
      data = 8'h00;
   end
   // One write strobe per request, data inverted between writes.
   always @(posedge ref_clk) begin
      wr <= req;
      data <= req ? cmd : ~data;
   end
endmodule

// ### tb_top.sv
// Self-checking testbench of the motor power stage fault manager.
`timescale 1ns/1ns
module tb_top
   import mpfm_pkg::*;
;
   logic       ref_clk, rst_n, pwm_in, en_pin, bemf_cmp, limit_cmp, overcurrent_cmp;
   logic       short_cmp, ext_temp_cmp, vs_low_cmp, vs_high_cmp, pump_low_cmp, vgl_low_cmp;
   logic       sleep_mode, lock_detect, zero_command, pwm_period_start, reset_cmd_wr, req;
   logic       gate_oe_q, speed_feedback_pin_q, speed_feedback_pin_oe_q, fault_output_pin_q;
   logic       fault_output_pin_oe_q, pwm_input_fault_flag_q, thermal_warning_q;
   logic       watchdog_fault_q, current_limit_warning_q;
   logic [9:0] duty_request, target_low, target_high, duty_out_q;
   logic [2:0] high_req, low_req, gate_high_q, gate_low_q;
   logic [7:0] die_temp, reset_cmd_data, cmd, diagnostic_errors_zero_q;
   mpfm_cfg_t  cfg;
   mpfm_ref_t  analog_ref_q;
   int         n_errors, tests_run, t;
   mpfm_top #(.TICK_CYC(4)) uut (.*);
   mpfm_mcu mcu (.ref_clk, .req, .cmd, .wr(reset_cmd_wr), .data(reset_cmd_data));
   task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic send(input logic [7:0] c);
      req <= 1'b1;
      cmd <= c;
      cyc(1);
      req <= 1'b0;
   endtask
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      #200000;
      n_errors++;
      end_sim();
   end
   initial begin
      {pwm_in, bemf_cmp, limit_cmp, overcurrent_cmp, short_cmp, ext_temp_cmp} = '0;
      {vs_low_cmp, vs_high_cmp, pump_low_cmp, vgl_low_cmp, sleep_mode, lock_detect} = '0;
      {zero_command, pwm_period_start, req, rst_n} = '0;
      {en_pin, high_req, low_req, cmd, cfg} = {1'b1, 3'h1, 3'h0, 8'h00, 63'h0};
      {duty_request, target_low, target_high, die_temp} = {30'h08010300, 8'h19};
      n_errors = 0;
      tests_run = 0;
      void'($urandom(2011));
      cyc(3);
      rst_n <= 1'b1;
      chk("fault_output_pin reset", 10'h0, diagnostic_errors_zero_q);
      cyc(3);
      chk("gate_oe", 10'h1, gate_oe_q);
      sleep_mode <= 1'b1;
      cyc(3);
      chk("gate_oe sleep", 10'h0, gate_oe_q);
      sleep_mode <= 1'b0;
      $display("Test sleep done");
      for (int i = 0; i < 3; i++) begin
         {vgl_low_cmp, pump_low_cmp, vs_low_cmp} <= 3'(1 << i);
         cyc(5);
         chk("fault_output_pin supply", 10'(8'h02 << (i ? i + 1 : 0)), diagnostic_errors_zero_q);
         chk("fault pin", 10'h1, fault_output_pin_oe_q);
         {vgl_low_cmp, pump_low_cmp, vs_low_cmp} <= 3'h0;
         cyc(5);
         chk("fault_output_pin recover", 10'h0, diagnostic_errors_zero_q);
      end
      cfg.fault_polarity_bit <= 1'b1;
      cyc(3);
      chk("fault pin idle", 10'h1, fault_output_pin_oe_q);
      cfg.fault_polarity_bit <= 1'b0;
      chk("gate on", 10'h1, gate_high_q);
      ext_temp_cmp <= 1'b1;
      cyc(5);
      chk("fault_output_pin ext", 10'h40, diagnostic_errors_zero_q);
      chk("gates ext", 10'h0, gate_high_q);
      ext_temp_cmp <= 1'b0;
      {high_req, low_req} <= 6'h01;
      cyc(20);
      chk("dead time", 10'h0, gate_low_q);
      cyc(10);
      chk("low gate", 10'h1, gate_low_q);
      {high_req, low_req} <= 6'h08;
      cyc(40);
      chk("high gate", 10'h1, gate_high_q);
      $display("Test supply and temperature done");
      cfg.overcurrent_protect_enable <= 1'b1;
      for (int l = 1; l >= 0; l--) begin
         cfg.overcurrent_latch_bit <= l[0];
         overcurrent_cmp <= 1'b1;
         cyc(40);
         overcurrent_cmp <= 1'b0;
         chk("oc gates", 10'h0, gate_high_q);
         cyc(1800);
         chk("oc held", 10'h1, diagnostic_errors_zero_q);
         cyc(300);
         chk("oc after", 10'(l), diagnostic_errors_zero_q);
         send(8'hff);
         cyc(5);
         chk("oc clear", 10'h0, diagnostic_errors_zero_q);
      end
      $display("Test overcurrent done");
      limit_cmp <= 1'b1;
      cyc(5);
      limit_cmp <= 1'b0;
      chk("limit gates", 10'h0, gate_high_q);
      chk("limit warn", 10'h1, current_limit_warning_q);
      cyc(3);
      pwm_period_start <= 1'b1;
      cyc(1);
      pwm_period_start <= 1'b0;
      cyc(30);
      chk("limit release", 10'h1, gate_high_q);
      chk("limit clear", 10'h0, current_limit_warning_q);
      chk("duty", 10'h080, duty_out_q);
      bemf_cmp <= 1'b1;
      cyc(5);
      chk("feedback", 10'h1, speed_feedback_pin_oe_q);
      $display("Test limit and feedback done");
      repeat (4) begin
         t = $urandom_range(160, 90);
         die_temp <= 8'(t);
         cyc(4);
         chk("thermal", 10'(t >= 125), thermal_warning_q);
      end
      die_temp <= 8'h19;
      cfg.watchdog_enable_bit <= 1'b1;
      for (int k = 1; k < 5; k++) begin
         cfg.watchdog_action_select <= 3'(k);
         send(8'h00);
         cyc(3);
         chk("wdt kick", 10'h0, watchdog_fault_q);
         cyc(90);
         chk("wdt", 10'h1, watchdog_fault_q);
         chk("wdt duty", 10'(256 * k - 1), duty_out_q);
      end
      $display("Test thermal and watchdog done");
      cyc(3500);
      chk("pwm fault", 10'h1, pwm_input_fault_flag_q);
      pwm_in <= 1'b1;
      cyc(5);
      chk("pwm edge", 10'h0, pwm_input_fault_flag_q);
      $display("Test input fault done");
      end_sim();
   end
endmodule
